//--- verilog/battery_flags_consts.vh
`ifndef BATTERY_FLAGS_CONSTS_VH
`define BATTERY_FLAGS_CONSTS_VH
// ==========================================================
// register word offsets (byte addresses)
`define OFS_BATT_STATUS   4'h0
`define OFS_ALARM_STATUS  4'h4
`define OFS_ALARM_MASK    4'h8
`define OFS_CONTROL       4'hc
// ==========================================================
// battery status field positions
`define BS_NORMAL   15
`define BS_ALERT    13
`define BS_FAULT    12
`define BS_SEC_HI   11
`define BS_SEC_LO   10
`define BS_AUTO     8
`define BS_FULLRST  7
`define BS_CFGEDIT  5
`define BS_PIN      4
`define BS_CHG      3
`define BS_DSG      2
`define BS_CHGDET   1
// ==========================================================
// alarm field positions and writable mask
`define AL_PFAULT   15
`define AL_SFAULT   14
`define AL_PALERT   13
`define AL_SALERT   12
`define AL_CHARGE_SWITCH_OFF_LATCH     11
`define AL_DISCHARGE_SWITCH_OFF_LATCH     10
`define AL_LOW_STACK_VOLTAGE_LATCH    9
`define AL_INIT     2
`define AL_CDTOG    1
`define AL_FULLRST  0
`define AL_IMPL     16'hfe07
`define ALARM_MASK_RST 16'hfe07
// ==========================================================
// security state codes
`define SEC_UNINIT  2'h0
`define SEC_FULL    2'h1
`define SEC_LOCKED  2'h3
// control register bits
`define CT_ENTER    0
`define CT_EXIT     1
`define CT_AUTO_WE  2
`define CT_AUTO_VAL 3
`define CT_MANCHG   4
`define CT_MANDSG   5
`endif

//--- verilog/battery_status_alarm_flags.v
// What this block does
// - bit 15 high only in normal mode
// - bit 13 high when enabled alert present
// - bit 12 high when enabled fault present
// - bits 11:10 report current security state
// - locked state refuses configuration access
// - autonomous bit loads option, subcommand changes
// - autonomous off: switches need manual command
// - bit 7 set on reset, cleared exiting edit
// - bit 5 set after enter subcommand done
// - configuration changes only in edit mode
// - bit 4 mirrors alert pin pulled low
// - bit 3 shows charge driver enabled
// - bit 2 shows discharge driver enabled
// - bit 1 shows debounced charger detect
// - any latched alarm drives alert low
// - write one clears only those alarm bits
// - alarm 15 latches on new primary fault while mask bit 15 set
`timescale 1ns/10ps
`include "battery_flags_consts.vh"

module battery_status_alarm_flags (
	input  wire        clk_i,            // 20 MHz clock
	input  wire        rst_i,            // sync reset, active high
	input  wire        cyc_i,            // wishbone cycle
	input  wire        stb_i,            // wishbone strobe
	input  wire        we_i,             // wishbone write
	input  wire [3:0]  adr_i,            // byte address
	input  wire [3:0]  sel_i,            // byte lanes
	input  wire [31:0] dat_i,            // write data
	output reg  [31:0] dat_o,            // read data
	output reg         ack_o,            // wishbone ack
	input  wire        normal_mode_i,    // device in normal mode
	input  wire [1:0]  security_state_field_i, // current security state
	input  wire [7:0]  fault_status_a_i, // enabled primary faults
	input  wire [7:0]  fault_status_b_i, // enabled secondary faults
	input  wire [7:0]  alert_status_a_i, // enabled primary alerts
	input  wire [7:0]  alert_status_b_i, // enabled secondary alerts
	input  wire        auto_option_i,    // stored autonomous option bit
	input  wire        charger_detect_level_i, // debounced detector
	input  wire        charge_block_i,   // condition prevents charge
	input  wire        discharge_block_i, // condition prevents discharge
	input  wire        shutdown_event_i, // low stack voltage pulse
	input  wire        init_done_i,      // init complete pulse
	input  wire        cfg_write_req_i,  // config change request pulse
	input  wire        cfg_read_req_i,   // config read request pulse
	output wire        cfg_write_ok_o,   // config change accepted
	output wire        cfg_read_ok_o,    // config read accepted
	output reg         charge_switch_driver_o,    // charge driver enable
	output reg         discharge_switch_driver_o, // discharge driver enable
	output wire        alert_pin_i_unused_o, // reserved, always low
	output wire        alert_o,          // alert pin drive value (0)
	output wire        alert_oe_n_o,     // low while pulling pin low
	output wire        irq_o             // level interrupt
);

	reg  [15:0] latched_alarm_flags;
	reg  [15:0] alarm_mask;
	reg         autonomous_switch_control;
	reg         config_edit_mode_flag;
	reg         full_reset_flag;
	reg         man_chg;
	reg         man_dsg;
	reg  [7:0]  prev_fault_a;
	reg  [7:0]  prev_fault_b;
	reg  [7:0]  prev_alert_a;
	reg  [7:0]  prev_alert_b;
	reg         prev_cdet;
	reg         prev_chg_on;
	reg         prev_dsg_on;
	wire [15:0] battery_status_flags;
	wire [15:0] alarm_set;
	wire [15:0] clr_bits;
	wire        req;
	wire        wr;
	wire        alert_pending_flag;
	wire        fault_pending;
	wire        locked;

	// lane-aware low half of write data
	function [15:0] lanes;
		input [31:0] d;
		input [3:0]  s;
		begin
			lanes = {d[15:8] & {8{s[1]}}, d[7:0] & {8{s[0]}}};
		end
	endfunction

	// ==========================================================
	// bus decode
	assign req = cyc_i & stb_i & ~ack_o;
	assign wr  = req & we_i;

	assign locked = (security_state_field_i == `SEC_LOCKED);
	assign cfg_write_ok_o = cfg_write_req_i & config_edit_mode_flag & ~locked;
	assign cfg_read_ok_o  = cfg_read_req_i & ~locked;

	// ==========================================================
	// status summary
	// alert and fault summary
	assign alert_pending_flag = |{alert_status_a_i, alert_status_b_i};
	assign fault_pending = |{fault_status_a_i, fault_status_b_i};

	assign battery_status_flags = {normal_mode_i, 1'b0, alert_pending_flag, fault_pending,
		security_state_field_i, 1'b0, autonomous_switch_control,
		full_reset_flag, 1'b0, config_edit_mode_flag, ~alert_oe_n_o,
		charge_switch_driver_o, discharge_switch_driver_o,
		charger_detect_level_i, 1'b0};

	// ==========================================================
	// alarm events (fault/alert rising edges, switch-off falling edges, detect toggles, event pulses)
	// primary fault latch
	assign alarm_set[`AL_PFAULT] = |(fault_status_a_i & ~prev_fault_a);
	assign alarm_set[`AL_SFAULT] = |(fault_status_b_i & ~prev_fault_b);
	assign alarm_set[`AL_PALERT] = |(alert_status_a_i & ~prev_alert_a);
	assign alarm_set[`AL_SALERT] = |(alert_status_b_i & ~prev_alert_b);
	assign alarm_set[`AL_CHARGE_SWITCH_OFF_LATCH]   = ~charge_switch_driver_o & prev_chg_on;
	assign alarm_set[`AL_DISCHARGE_SWITCH_OFF_LATCH]   = ~discharge_switch_driver_o & prev_dsg_on;
	assign alarm_set[`AL_LOW_STACK_VOLTAGE_LATCH]  = shutdown_event_i;
	assign alarm_set[8:3]        = 6'h00;
	assign alarm_set[`AL_INIT]   = init_done_i;
	assign alarm_set[`AL_CDTOG]  = charger_detect_level_i ^ prev_cdet;
	assign alarm_set[`AL_FULLRST] = 1'b0;

	assign clr_bits = (wr && adr_i == `OFS_ALARM_STATUS) ? lanes(dat_i, sel_i) : 16'h0000;

	// ==========================================================
	// alarm register, set wins over clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			latched_alarm_flags <= 16'h0001;
		end else begin
			latched_alarm_flags <= ((latched_alarm_flags & ~clr_bits) |
				(alarm_set & alarm_mask)) & `AL_IMPL;
		end
	end

	assign alert_o              = 1'b0;
	assign alert_oe_n_o         = ~|latched_alarm_flags;
	assign alert_pin_i_unused_o = 1'b0;
	assign irq_o                = ~alert_oe_n_o;

	// ==========================================================
	// control state
	always @(posedge clk_i) begin
		if (rst_i) begin
			alarm_mask                <= `ALARM_MASK_RST;
			autonomous_switch_control <= 1'b0;
			config_edit_mode_flag     <= 1'b0;
			full_reset_flag           <= 1'b1;
			man_chg                   <= 1'b0;
			man_dsg                   <= 1'b0;
		end else if (wr && adr_i == `OFS_ALARM_MASK) begin
			alarm_mask <= lanes(dat_i, sel_i) & `AL_IMPL;
		end else if (wr && adr_i == `OFS_CONTROL && sel_i[0]) begin
			man_chg <= dat_i[`CT_MANCHG];
			man_dsg <= dat_i[`CT_MANDSG];
			if (dat_i[`CT_ENTER] && !locked) begin
				config_edit_mode_flag <= 1'b1;
			end else if (dat_i[`CT_EXIT] && config_edit_mode_flag) begin
				config_edit_mode_flag <= 1'b0;
				full_reset_flag <= 1'b0;
				autonomous_switch_control <= auto_option_i;
			end else if (dat_i[`CT_AUTO_WE]) begin
				autonomous_switch_control <= dat_i[`CT_AUTO_VAL];
			end
		end
	end

	// ==========================================================
	// switch drivers and edge history
	always @(posedge clk_i) begin
		if (rst_i) begin
			charge_switch_driver_o    <= 1'b0;
			discharge_switch_driver_o <= 1'b0;
			prev_fault_a              <= 8'h00;
			prev_fault_b              <= 8'h00;
			prev_alert_a              <= 8'h00;
			prev_alert_b              <= 8'h00;
			prev_cdet                 <= 1'b0;
			prev_chg_on               <= 1'b0;
			prev_dsg_on               <= 1'b0;
		end else begin
			charge_switch_driver_o    <= (man_chg | autonomous_switch_control) & ~charge_block_i;
			discharge_switch_driver_o <= (man_dsg | autonomous_switch_control) &
				~discharge_block_i;
			prev_fault_a <= fault_status_a_i;
			prev_fault_b <= fault_status_b_i;
			prev_alert_a <= alert_status_a_i;
			prev_alert_b <= alert_status_b_i;
			prev_cdet    <= charger_detect_level_i;
			prev_chg_on  <= charge_switch_driver_o;
			prev_dsg_on  <= discharge_switch_driver_o;
		end
	end

	// ==========================================================
	// bus answer, one cycle after request
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req;
			if (req && !we_i) begin
				case (adr_i)
					`OFS_BATT_STATUS:  dat_o <= {16'h0000, battery_status_flags};
					`OFS_ALARM_STATUS: dat_o <= {16'h0000, latched_alarm_flags};
					`OFS_ALARM_MASK:   dat_o <= {16'h0000, alarm_mask};
					`OFS_CONTROL:      dat_o <= {26'h0000000, man_dsg, man_chg, 4'h0};
					default:           dat_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // battery_status_alarm_flags

//--- dv/battery_flags_sva.sv
`timescale 1ns/10ps
// ==========================================================
// port-level checks of the flag block
module battery_flags_sva (
	input wire        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, alert_o, alert_oe_n_o,
	input wire        cfg_read_req_i, cfg_write_req_i, cfg_read_ok_o, cfg_write_ok_o,
	input wire        charge_block_i, discharge_block_i,
	input wire        charge_switch_driver_o, discharge_switch_driver_o,
	input wire [1:0]  security_state_field_i,
	input wire [3:0]  adr_i, sel_i,
	input wire [7:0]  fault_status_a_i,
	input wire [31:0] dat_i, dat_o
);
	reg m15; // mask bit of the primary fault alarm
	// follow mask writes seen on the bus
	always @(posedge clk_i) begin
		if (rst_i)
			m15 <= 1'b1;
		else if (cyc_i && stb_i && ack_o && we_i && adr_i == 4'h8 && sel_i[1])
			m15 <= dat_i[15];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack after request");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0)
		else $error("upper read bits not zero");
	a_pin_irq: assert property (irq_o == !alert_oe_n_o && !alert_o)
		else $error("pin and irq disagree");
	a_fault_alarm: assert property ($rose(|fault_status_a_i) && m15 |-> ##[1:2] !alert_oe_n_o)
		else $error("primary fault not latched");
	a_locked_refuse: assert property (security_state_field_i == 2'h3 |-> !cfg_read_ok_o && !cfg_write_ok_o)
		else $error("locked access accepted");
	a_full_read: assert property (security_state_field_i == 2'h1 && cfg_read_req_i |-> cfg_read_ok_o)
		else $error("full access read refused");
	a_write_req: assert property (cfg_write_ok_o |-> cfg_write_req_i)
		else $error("write ok without request");
	a_chg_block: assert property ($rose(charge_block_i) |-> ##[1:2] !charge_switch_driver_o)
		else $error("charge driver not blocked");
	a_dsg_block: assert property ($rose(discharge_block_i) |-> ##[1:2] !discharge_switch_driver_o)
		else $error("discharge driver not blocked");
endmodule // battery_flags_sva

//--- dv/test_battery_status_alarm_flags.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
// ==========================================================
// bench for the flag block
module test_battery_status_alarm_flags;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, normal_mode_i = 0, auto_option_i = 0;
	logic charger_detect_level_i = 0, charge_block_i = 0, discharge_block_i = 0;
	logic shutdown_event_i = 0, init_done_i = 0, cfg_write_req_i = 0, cfg_read_req_i = 0;
	logic [1:0] security_state_field_i = 2'h1;
	logic [3:0] adr_i = 4'h0, sel_i = 4'h3;
	logic [7:0] fault_status_a_i = 0, fault_status_b_i = 0, alert_status_a_i = 0, alert_status_b_i = 0;
	logic [15:0] al, w;
	logic [31:0] dat_i = 0, rdat;
	wire [31:0] dat_o;
	wire ack_o, cfg_write_ok_o, cfg_read_ok_o, charge_switch_driver_o, discharge_switch_driver_o;
	wire alert_pin_i_unused_o, alert_o, alert_oe_n_o, irq_o;
	int n_fail = 0, num_checks = 0, cyc_cnt = 0;
	battery_status_alarm_flags dut (.*);
	always #25 clk_i = ~clk_i;
	// hang guard
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic conclude();
		if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one classic wishbone cycle
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= wr;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		rdat = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		bus(0, a, 0);
		`CHK("read", {16'h0, e}, rdat)
	endtask
	// config request, checks accept flags
	task automatic cfg(input logic ew, input logic er);
		cfg_write_req_i <= 1;
		cfg_read_req_i <= 1;
		@(negedge clk_i);
		`CHK("cfg_write_ok", ew, cfg_write_ok_o)
		`CHK("cfg_read_ok", er, cfg_read_ok_o)
		@(posedge clk_i);
		cfg_write_req_i <= 0;
		cfg_read_req_i <= 0;
	endtask
	task automatic pulse(input logic s, input logic i);
		shutdown_event_i <= s;
		init_done_i <= i;
		@(posedge clk_i);
		shutdown_event_i <= 0;
		init_done_i <= 0;
		repeat (2) @(posedge clk_i);
	endtask
	// expected status word from current inputs
	function automatic logic [15:0] stat(input logic p, ed, au, pr, cg, dg);
		return {normal_mode_i, 1'b0, |{alert_status_a_i, alert_status_b_i},
			|{fault_status_a_i, fault_status_b_i}, security_state_field_i, 1'b0, au, pr,
			1'b0, ed, p, cg, dg, charger_detect_level_i, 1'b0};
	endfunction
	function automatic logic [7:0] r8();
		return ($urandom % 2) ? 8'h0 : 8'($urandom);
	endfunction
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(52311));
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		bus(1, 4'h0, 32'hffff);
		rd(4'h0, stat(1, 0, 0, 1, 0, 0));
		rd(4'h4, 16'h0001);
		rd(4'h8, 16'hfe07);
		bus(1, 4'h4, 32'h0001);
		rd(4'h4, 16'h0000);
		`CHK("irq", 1'b0, irq_o)
		`CHK("alert_pin_unused", 1'b0, alert_pin_i_unused_o)
		rd(4'h2, 16'h0000);
		// random flag inputs, alarms, partial clears
		repeat (24) begin
			normal_mode_i <= $urandom;
			security_state_field_i <= ($urandom % 3 == 0) ? 2'h3 : 2'($urandom % 2);
			{fault_status_a_i, fault_status_b_i} <= {r8(), r8()};
			{alert_status_a_i, alert_status_b_i} <= {r8(), r8()};
			charger_detect_level_i <= $urandom;
			w = 16'($urandom);
			repeat (3) @(posedge clk_i);
			al = {|fault_status_a_i, |fault_status_b_i, |alert_status_a_i, |alert_status_b_i,
				10'h0, charger_detect_level_i, 1'b0};
			rd(4'h0, stat(al != 0, 0, 0, 1, 0, 0));
			rd(4'h4, al);
			bus(1, 4'h4, {16'h0, w});
			rd(4'h4, al & ~w);
			{fault_status_a_i, fault_status_b_i, alert_status_a_i, alert_status_b_i} <= 0;
			charger_detect_level_i <= 0;
			repeat (3) @(posedge clk_i);
			bus(1, 4'h4, 32'hffff);
		end
		bus(1, 4'h8, 32'h0);
		pulse(1, 1);
		rd(4'h4, 16'h0000);
		`CHK("irq", 1'b0, irq_o)
		bus(1, 4'h8, 32'hfe07);
		pulse(1, 1);
		`CHK("irq", 1'b1, irq_o)
		bus(1, 4'h4, 32'h0200);
		rd(4'h4, 16'h0004);
		bus(1, 4'h4, 32'h0004);
		// edit mode entry, exit and autonomous control
		security_state_field_i <= 2'h1;
		cfg(0, 1);
		bus(1, 4'hc, 32'h1);
		rd(4'h0, stat(0, 1, 0, 1, 0, 0));
		cfg(1, 1);
		auto_option_i <= 1;
		bus(1, 4'hc, 32'h2);
		rd(4'h0, stat(0, 0, 1, 0, 1, 1));
		bus(1, 4'hc, 32'h4);
		rd(4'h0, stat(1, 0, 0, 0, 0, 0));
		bus(1, 4'hc, 32'h30);
		rd(4'h0, stat(1, 0, 0, 0, 1, 1));
		{charge_block_i, discharge_block_i} <= 2'b11;
		repeat (3) @(posedge clk_i);
		rd(4'h4, 16'h0c00);
		rd(4'h0, stat(1, 0, 0, 0, 0, 0));
		security_state_field_i <= 2'h3;
		bus(1, 4'hc, 32'h1);
		rd(4'h0, stat(1, 0, 0, 0, 0, 0));
		cfg(0, 0);
		conclude();
	end
endmodule // test_battery_status_alarm_flags
bind battery_status_alarm_flags battery_flags_sva chk (.*);
